// >>> inc/pcbr_pkg.sv
// Constants, register map and carrier types of the two-slot card bridge.
// Assumes one 100 MHz system clock and a sampled ISA pin set.
package pcbr_pkg;
	// ***********************
	// Register map, per slot
	// ***********************
	localparam logic [5:0] R_ID = 6'h00;
	localparam logic [5:0] R_IFSTAT = 6'h01;
	localparam logic [5:0] R_PWR = 6'h02;
	localparam logic [5:0] R_IGC = 6'h03;
	localparam logic [5:0] R_CSC = 6'h04;
	localparam logic [5:0] R_CSCCFG = 6'h05;
	localparam logic [5:0] R_WINEN = 6'h06;
	localparam logic [5:0] R_IOCTL = 6'h07;
	localparam logic [5:0] R_IOWIN = 6'h08;
	localparam logic [5:0] R_MEMWIN = 6'h10;
	localparam logic [5:0] R_VCTL = 6'h17;
	localparam logic [5:0] R_GCTL = 6'h1E;
	localparam int IOWIN_STEP = 4;
	localparam int MEMWIN_STEP = 8;
	localparam logic [15:0] IO_INDEX = 16'h03E0;
	localparam logic [15:0] IO_DATA = 16'h03E1;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Card pins lag two edges through the synchronisers
	localparam logic [1:0] SYNC_SETTLE = 2'h2;
	// ***********************
	// Field positions
	// ***********************
	localparam int IGC_ATTR = 4;
	localparam int IGC_IOMODE = 5;
	localparam int CFG_STS = 0;
	localparam int CFG_DET = 3;
	localparam int WIN_IO0 = 6;
	localparam int MSH_WS = 4;
	localparam int MSH_ZW = 6;
	localparam int MSH_16 = 7;
	localparam int OFH_ATTR = 6;
	localparam int IOC_16 = 0;
	localparam int IOC_SRC = 1;
	localparam int IOC_ZW = 2;
	localparam int IOC_WS = 3;
	localparam int VCTL_EN0 = 0;
	localparam int VCTL_EN1 = 1;
	localparam int PWR_V0 = 0;
	localparam int PWR_V1 = 1;
	localparam int GCTL_LEVEL = 1;
	localparam int IRQ_N = 16;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_CARD = 2'b10,
		ST_END = 2'b11
	} pcbr_state_t;
	typedef struct packed {
		logic casSel;
		logic [15:0] cdat;
		logic [15:0] sd;
		logic aen;
		logic iowN;
		logic iorN;
		logic memwN;
		logic memrN;
		logic sbheN;
		logic [23:0] addr;
	} pcbr_isa_t;
	typedef struct packed {
		logic cdA;
		logic cdB;
		logic vsA;
		logic vsB;
		logic bdA;
		logic bdB;
		logic rdy;
		logic wp;
		logic waitN;
	} pcbr_cardin_t;
	typedef struct packed {
		logic ce1N;
		logic ce2N;
		logic regN;
		logic oeN;
		logic weN;
		logic iordN;
		logic iowrN;
	} pcbr_cardout_t;
	localparam pcbr_cardout_t CARD_IDLE = 7'h7F;
endpackage : pcbr_pkg

// >>> design/pcbr_bridge.sv
// ISA to two-slot card bridge: FIFO and top module.
// Assumes all pins are asynchronous to clk_sys and are synchronised here.
// What this block does
// - Supply enables follow voltage control bits
// - Programming voltage outputs follow power control
// - Attribute and common spaces, 64 MB each
// - Attribute select from control and offset bits
// - Memory window start, stop, offset, 4 KB
// - Five memory windows, each with enable
// - Byte-high strobe selects 8 or 16 bit
// - Memory card enables from A0 and size
// - I/O card enables from A0, IOIS16, control
// - Card wait holds channel ready low
// - Memory window wait states and zero-wait
// - I/O window wait states and zero-wait
// - Card I/O space only through windows
// - I/O window byte-granular start to stop
// - Two I/O windows, each with enable
// - I/O cycles: attribute low, own strobes
// - Index 00-3F slot A, 40-7F B
// - Cascade select moves indexes to 80-FF
// - Index port then data port access
// - Mode bit reassigns dual-purpose card pins
// - Detect, power and sense pins sampled
// - Memory-only status; I/O mode status change
// - Card interrupt steered to selected line
// - Interrupt lines active high, or inverted by level bit
`timescale 1ns/100ps
module pcbr_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp, rp, next_wp, next_rp;
	logic push, pop;
	always_comb
	begin
		inReady = (wp - rp) != (AW+1)'(DEPTH);
		outValid = wp != rp;
		outData = mem[rp[AW-1:0]];
		push = inValid && inReady;
		pop = outValid && outReady;
		next_wp = push ? wp + 1'b1 : wp;
		next_rp = pop ? rp + 1'b1 : rp;
	end
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp <= '0;
			rp <= '0;
		end
		else
		begin
			wp <= next_wp;
			rp <= next_rp;
		end
	end
	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem[wp[AW-1:0]] <= inData;
	end
endmodule : pcbr_fifo

module pcbr_bridge #(
	parameter logic [7:0] ID_VALUE = 8'h5A, // Arbitrary value
	parameter int FIFO_DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire pcbr_pkg::pcbr_isa_t isaPins,
	input wire pcbr_pkg::pcbr_cardin_t [1:0] cardIn,
	output logic [15:0] sdOut,
	output logic sdOe,
	output logic channelReadyOut,
	output logic zeroWaitOut_n,
	output pcbr_pkg::pcbr_cardout_t [1:0] cardCtl,
	output logic [25:0] cardAddr,
	output logic [15:0] cardDataOut,
	output logic cardDataOe,
	output logic [15:0] irqOut,
	output logic [1:0] cardSupplyEnable0,
	output logic [1:0] cardSupplyEnable1,
	output logic [1:0] progVoltageCtrl0,
	output logic [1:0] progVoltageCtrl1
);
	function automatic logic inWin(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction : inWin
	// Returns {ce2N, ce1N}
	function automatic logic [1:0] ceSel(input logic is16, input logic a0,
		input logic sbheN);
		if (!is16 || (sbheN && !a0))
			return 2'b10;
		if (a0)
			return 2'b01;
		return 2'b00;
	endfunction : ceSel
	// ***********************
	// Pin synchronisers
	// ***********************
	pcbr_pkg::pcbr_isa_t isaS1, isaS2;
	pcbr_pkg::pcbr_cardin_t [1:0] cardS1, cardS2;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			isaS1 <= '1;
			isaS2 <= '1;
			cardS1 <= '1;
			cardS2 <= '1;
		end
		else
		begin
			isaS1 <= isaPins;
			isaS2 <= isaS1;
			cardS1 <= cardIn;
			cardS2 <= cardS1;
		end
	end
	// ***********************
	// Register file
	// ***********************
	logic [7:0] regs [128];
	logic regWe, popValid, popReady, pushValid, pushReady;
	logic [6:0] regWIdx;
	logic [7:0] regWData;
	logic [14:0] popData;
	pcbr_pkg::pcbr_state_t state, next_state;
	logic [7:0] index, next_index;
	always_comb
	begin
		popReady = (state != pcbr_pkg::ST_WAIT) && (state != pcbr_pkg::ST_CARD);
		regWe = popValid && popReady;
		regWIdx = popData[14:8];
		regWData = popData[7:0];
	end
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 128; i++)
				regs[i] <= pcbr_pkg::REG_RESET;
		end
		else if (regWe)
			regs[regWIdx] <= regWData;
	end
	for (genvar s = 0; s < 2; s++)
	begin : g_pwr
		assign cardSupplyEnable0[s] = regs[{1'(s), pcbr_pkg::R_VCTL}][pcbr_pkg::VCTL_EN0];
		assign cardSupplyEnable1[s] = regs[{1'(s), pcbr_pkg::R_VCTL}][pcbr_pkg::VCTL_EN1];
		assign progVoltageCtrl0[s] = regs[{1'(s), pcbr_pkg::R_PWR}][pcbr_pkg::PWR_V0];
		assign progVoltageCtrl1[s] = regs[{1'(s), pcbr_pkg::R_PWR}][pcbr_pkg::PWR_V1];
	end
	// ***********************
	// Window decode
	// ***********************
	logic isMem, isIo, cmd, wr, rd, ownIdx, hitMem, hitIo, hitSlot, hitZw;
	logic [2:0] hitWin;
	logic [1:0] hitWs;
	logic [25:0] hitAddr;
	pcbr_pkg::pcbr_cardout_t hitCtl;
	always_comb
	begin
		logic [6:0] b;
		logic [13:0] off;
		logic [3:0] nib;
		logic [7:0] igc;
		b = '0;
		off = '0;
		nib = '0;
		igc = '0;
		isMem = !isaS2.memrN || !isaS2.memwN;
		isIo = (!isaS2.iorN || !isaS2.iowN) && !isaS2.aen;
		cmd = isMem || isIo;
		wr = !isaS2.memwN || !isaS2.iowN;
		rd = !isaS2.memrN || !isaS2.iorN;
		ownIdx = (index[7] == isaS2.casSel);
		hitMem = 1'b0;
		hitIo = 1'b0;
		hitSlot = 1'b0;
		hitWin = '0;
		hitWs = '0;
		hitZw = 1'b0;
		hitAddr = '0;
		hitCtl = pcbr_pkg::CARD_IDLE;
		for (int s = 0; s < 2; s++)
		begin
			igc = regs[7'(s * 64) + 7'(pcbr_pkg::R_IGC)];
			for (int w = 0; w < 5; w++)
			begin
				b = 7'(s * 64 + pcbr_pkg::R_MEMWIN + pcbr_pkg::MEMWIN_STEP * w);
				if (isMem && !hitMem && regs[7'(s * 64) + 7'(pcbr_pkg::R_WINEN)][w]
					&& inWin({4'h0, isaS2.addr[23:12]}, {4'h0, regs[b + 7'd1][3:0], regs[b]},
					{4'h0, regs[b + 7'd3][3:0], regs[b + 7'd2]}))
				begin
					hitMem = 1'b1;
					hitSlot = s[0];
					hitWin = w[2:0];
					off = {regs[b + 7'd5][5:0], regs[b + 7'd4]};
					hitAddr = {14'(isaS2.addr[23:12] + off), isaS2.addr[11:0]};
					hitWs = regs[b + 7'd1][pcbr_pkg::MSH_WS +: 2];
					hitZw = regs[b + 7'd1][pcbr_pkg::MSH_ZW];
					{hitCtl.ce2N, hitCtl.ce1N} = ceSel(regs[b + 7'd1][pcbr_pkg::MSH_16],
						isaS2.addr[0], isaS2.sbheN);
					hitCtl.regN = !(regs[b + 7'd5][pcbr_pkg::OFH_ATTR]
						&& igc[pcbr_pkg::IGC_ATTR]);
					hitCtl.oeN = isaS2.memrN;
					hitCtl.weN = isaS2.memwN;
				end
			end
			for (int w = 0; w < 2; w++)
			begin
				b = 7'(s * 64 + pcbr_pkg::R_IOWIN + pcbr_pkg::IOWIN_STEP * w);
				nib = regs[7'(s * 64) + 7'(pcbr_pkg::R_IOCTL)][4 * w +: 4];
				if (isIo && !hitMem && !hitIo
					&& regs[7'(s * 64) + 7'(pcbr_pkg::R_WINEN)][pcbr_pkg::WIN_IO0 + w]
					&& inWin(isaS2.addr[15:0], {regs[b + 7'd1], regs[b]},
					{regs[b + 7'd3], regs[b + 7'd2]}))
				begin
					hitIo = 1'b1;
					hitSlot = s[0];
					hitWin = 3'(5 + w);
					hitAddr = {10'h000, isaS2.addr[15:0]};
					hitWs = {1'b0, nib[pcbr_pkg::IOC_WS]};
					hitZw = nib[pcbr_pkg::IOC_ZW];
					{hitCtl.ce2N, hitCtl.ce1N} = ceSel(nib[pcbr_pkg::IOC_SRC] ? !cardS2[s].wp
						: nib[pcbr_pkg::IOC_16], isaS2.addr[0], isaS2.sbheN);
					hitCtl.regN = 1'b0;
					hitCtl.iordN = isaS2.iorN;
					hitCtl.iowrN = isaS2.iowN;
				end
			end
		end
	end
	// ***********************
	// Register read data
	// ***********************
	logic [7:0] rdData;
	logic [1:0][7:0] ifStat;
	logic [1:0][1:0] cscFlag, cscSet, next_csc;
	always_comb
	begin
		logic s;
		s = index[6];
		case (index[5:0])
			pcbr_pkg::R_ID: rdData = ID_VALUE;
			pcbr_pkg::R_IFSTAT: rdData = ifStat[s];
			pcbr_pkg::R_CSC: rdData = {4'h0, cscFlag[s][1], 2'b00, cscFlag[s][0]};
			pcbr_pkg::R_VCTL: rdData = {2'b00, cardS2[s].vsB, cardS2[s].vsA,
				regs[index[6:0]][3:0]};
			default: rdData = regs[index[6:0]];
		endcase
	end
	// ***********************
	// Status change and interrupts
	// ***********************
	logic [1:0] prevCd, prevSts, next_prevCd, next_prevSts;
	logic [15:0] next_irq;
	always_comb
	begin
		logic [15:0] req;
		logic io;
		logic [7:0] cfg, igc;
		req = '0;
		io = 1'b0;
		cfg = '0;
		igc = '0;
		for (int s = 0; s < 2; s++)
		begin
			igc = regs[7'(s * 64) + 7'(pcbr_pkg::R_IGC)];
			cfg = regs[7'(s * 64) + 7'(pcbr_pkg::R_CSCCFG)];
			io = igc[pcbr_pkg::IGC_IOMODE];
			next_prevCd[s] = !cardS2[s].cdA && !cardS2[s].cdB;
			next_prevSts[s] = io && !cardS2[s].bdA;
			ifStat[s] = {|{cardSupplyEnable0[s], cardSupplyEnable1[s]},
				io ? 3'b000 : {cardS2[s].rdy, cardS2[s].wp, 1'b0},
				!cardS2[s].cdB, !cardS2[s].cdA,
				io ? 1'b0 : cardS2[s].bdB, io ? !cardS2[s].bdA : cardS2[s].bdA};
			cscSet[s] = {next_prevCd[s] != prevCd[s], next_prevSts[s] && !prevSts[s]};
			for (int k = 0; k < 2; k++)
				next_csc[s][k] = cscSet[s][k] || (cscFlag[s][k] && !(regWe
					&& regWIdx == {s[0], pcbr_pkg::R_CSC} && regWData[k * 3]));
			if ((cscFlag[s][1] && cfg[pcbr_pkg::CFG_DET])
				|| (cscFlag[s][0] && cfg[pcbr_pkg::CFG_STS]))
				req[cfg[7:4]] = 1'b1;
			if (io && !cardS2[s].rdy)
				req[igc[3:0]] = 1'b1;
		end
		req[0] = 1'b0;
		next_irq = regs[7'(pcbr_pkg::R_GCTL)][pcbr_pkg::GCTL_LEVEL] ? ~req : req;
	end
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prevCd <= '0;
			prevSts <= '0;
			cscFlag <= '0;
			irqOut <= '0;
		end
		else
		begin
			prevCd <= next_prevCd;
			prevSts <= next_prevSts;
			cscFlag <= next_csc;
			irqOut <= next_irq;
		end
	end
	// ***********************
	// Cycle engine
	// ***********************
	logic [1:0] waitCnt, next_waitCnt;
	logic curSlot, next_slot, next_chRdy, next_zwN, next_sdOe, next_cDatOe;
	logic [15:0] next_sdOut, next_cDat;
	logic [25:0] next_cAddr;
	pcbr_pkg::pcbr_cardout_t [1:0] next_ctl;
	pcbr_fifo #(.WIDTH(15), .DEPTH(FIFO_DEPTH)) u_wrq (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.inValid(pushValid),
		.inReady(pushReady),
		.inData({index[6:0], isaS2.sd[7:0]}),
		.outValid(popValid),
		.outReady(popReady),
		.outData(popData)
	);
	always_comb
	begin
		next_state = state;
		next_index = index;
		next_waitCnt = waitCnt;
		next_slot = curSlot;
		next_chRdy = channelReadyOut;
		next_zwN = zeroWaitOut_n;
		next_sdOut = sdOut;
		next_sdOe = sdOe;
		next_ctl = cardCtl;
		next_cAddr = cardAddr;
		next_cDat = cardDataOut;
		next_cDatOe = cardDataOe;
		pushValid = 1'b0;
		case (state)
			pcbr_pkg::ST_IDLE:
				if (cmd)
				begin
					if (isIo && isaS2.addr[15:0] == pcbr_pkg::IO_INDEX)
					begin
						if (rd)
						begin
							next_sdOut = {8'h00, index};
							next_sdOe = 1'b1;
						end
						else
							next_index = isaS2.sd[7:0];
						next_state = pcbr_pkg::ST_END;
					end
					else if (isIo && isaS2.addr[15:0] == pcbr_pkg::IO_DATA && ownIdx)
					begin
						if (wr)
						begin
							pushValid = 1'b1;
							next_chRdy = pushReady;
							if (pushReady)
								next_state = pcbr_pkg::ST_END;
						end
						else if (popValid)
							next_chRdy = 1'b0;
						else
						begin
							next_sdOut = {8'h00, rdData};
							next_sdOe = 1'b1;
							next_chRdy = 1'b1;
							next_state = pcbr_pkg::ST_END;
						end
					end
					else if (hitMem || hitIo)
					begin
						next_slot = hitSlot;
						next_waitCnt = hitWs;
						next_chRdy = hitZw && hitWs == 2'b00;
						next_zwN = !hitZw;
						next_cAddr = hitAddr;
						next_ctl[hitSlot] = hitCtl;
						next_cDat = isaS2.sd;
						next_cDatOe = wr;
						next_state = pcbr_pkg::ST_WAIT;
					end
					else
						next_state = pcbr_pkg::ST_END;
				end
			pcbr_pkg::ST_WAIT:
				if (waitCnt == 2'b00)
				begin
					next_waitCnt = pcbr_pkg::SYNC_SETTLE;
					next_state = pcbr_pkg::ST_CARD;
				end
				else
				begin
					next_chRdy = 1'b0;
					next_waitCnt = waitCnt - 2'b01;
				end
			pcbr_pkg::ST_CARD:
				if (!cardS2[curSlot].waitN)
					next_chRdy = 1'b0;
				else if (waitCnt != 2'b00)
					// Card wait and data are trusted only once the pin lag has passed
					next_waitCnt = waitCnt - 2'b01;
				else
				begin
					next_chRdy = 1'b1;
					next_sdOut = isaS2.cdat;
					next_sdOe = rd;
					next_state = pcbr_pkg::ST_END;
				end
			pcbr_pkg::ST_END:
				if (!cmd)
				begin
					next_ctl = {pcbr_pkg::CARD_IDLE, pcbr_pkg::CARD_IDLE};
					next_sdOe = 1'b0;
					next_cDatOe = 1'b0;
					next_zwN = 1'b1;
					next_chRdy = 1'b1;
					next_state = pcbr_pkg::ST_IDLE;
				end
			default: next_state = pcbr_pkg::ST_IDLE;
		endcase
	end
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= pcbr_pkg::ST_IDLE;
			index <= '0;
			waitCnt <= '0;
			curSlot <= 1'b0;
			channelReadyOut <= 1'b1;
			zeroWaitOut_n <= 1'b1;
			sdOut <= '0;
			sdOe <= 1'b0;
			cardCtl <= {pcbr_pkg::CARD_IDLE, pcbr_pkg::CARD_IDLE};
			cardAddr <= '0;
			cardDataOut <= '0;
			cardDataOe <= 1'b0;
		end
		else
		begin
			state <= next_state;
			index <= next_index;
			waitCnt <= next_waitCnt;
			curSlot <= next_slot;
			channelReadyOut <= next_chRdy;
			zeroWaitOut_n <= next_zwN;
			sdOut <= next_sdOut;
			sdOe <= next_sdOe;
			cardCtl <= next_ctl;
			cardAddr <= next_cAddr;
			cardDataOut <= next_cDat;
			cardDataOe <= next_cDatOe;
		end
	end
	// ***********************
	// Assertions
	// ***********************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_card_wait_rdy: assert property (state == pcbr_pkg::ST_CARD
		&& !cardS2[curSlot].waitN |=> !channelReadyOut)
		else $error("channel ready high during card wait");
	a_io_strobe_use: assert property (!cardCtl[0].iordN || !cardCtl[0].iowrN
		|-> !cardCtl[0].regN && cardCtl[0].oeN && cardCtl[0].weN)
		else $error("I/O cycle with memory strobes");
	a_supply_en_a: assert property (regWe && regWIdx == 7'h17
		|=> cardSupplyEnable0[0] == $past(regWData[0]) && cardSupplyEnable1[0] == $past(regWData[1]))
		else $error("supply enable not following register");
	a_vpp_ctrl_b: assert property (regWe && regWIdx == 7'h42
		|=> progVoltageCtrl0[1] == $past(regWData[0]) && progVoltageCtrl1[1] == $past(regWData[1]))
		else $error("programming voltage not following register");
	a_cascade_ignore: assert property (!ownIdx |-> !pushValid)
		else $error("foreign index accepted");
	a_csc_set_wins: assert property (cscSet[0][1] |=> cscFlag[0][1])
		else $error("status change lost");
	a_wait_count: assert property (state == pcbr_pkg::ST_WAIT && waitCnt != 2'b00
		|=> state == pcbr_pkg::ST_WAIT && waitCnt == $past(waitCnt) - 2'b01)
		else $error("wait state count wrong");
	a_win_enabled: assert property (state == pcbr_pkg::ST_IDLE && hitMem
		|-> regs[{hitSlot, pcbr_pkg::R_WINEN}][hitWin])
		else $error("disabled window hit");
	a_index_write: assert property (state == pcbr_pkg::ST_IDLE && isIo && wr
		&& isaS2.addr[15:0] == pcbr_pkg::IO_INDEX |=> index == $past(isaS2.sd[7:0]))
		else $error("index not written");
	c_mem_wait: cover property (state == pcbr_pkg::ST_CARD && !cardS2[curSlot].waitN);
	c_io_cycle: cover property (!cardCtl[1].iordN);
	c_fifo_full: cover property (pushValid && !pushReady);
endmodule : pcbr_bridge

// >>> dv/pcbr_card_model.sv
// Behavioural card for slot A: answers reads with address-derived data.
// Assumes the bridge holds card strobes and address steady during a cycle.
`timescale 1ns/100ps
module pcbr_card_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire pcbr_pkg::pcbr_cardout_t ctl,
	input wire logic [25:0] addr,
	input wire logic [3:0] waitLen,
	output logic [15:0] cdat,
	output logic waitN
);
	logic [3:0] cnt;
	logic [15:0] last;
	logic rd;
	logic busy;
	assign rd = !ctl.oeN || !ctl.iordN;
	assign busy = rd || !ctl.weN || !ctl.iowrN;
	// Released bus shows a pattern that changes every cycle
	assign cdat = rd ? (addr[15:0] ^ 16'ha5c3) : ~last;
	assign waitN = !(busy && cnt < waitLen);
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 4'h0;
			last <= 16'h0000;
		end
		else
		begin
			cnt <= busy ? ((cnt == 4'hf) ? cnt : cnt + 4'h1) : 4'h0;
			last <= cdat;
		end
	end
endmodule : pcbr_card_model

// >>> dv/tb_isa_to_pc_card_bridge.sv
// Self-checking bench of the card bridge: registers, windows, status, interrupts.
// Assumes the card model sits on slot A and slot B stays idle.
`timescale 1ns/100ps
module tb_isa_to_pc_card_bridge;
	// ****
	// Harness
	// ****
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	pcbr_pkg::pcbr_isa_t isa, isaPins;
	pcbr_pkg::pcbr_cardin_t [1:0] cin, cardIn;
	pcbr_pkg::pcbr_cardout_t [1:0] cardCtl;
	pcbr_pkg::pcbr_cardout_t ctlSeen;
	logic [15:0] sdOut, cardDataOut, irqOut, mdat, dataSeen;
	logic sdOe, channelReadyOut, zeroWaitOut_n, cardDataOe, mwaitN, zwSeen, oeSeen;
	logic [25:0] cardAddr, addrSeen;
	logic [1:0] cardSupplyEnable0, cardSupplyEnable1, progVoltageCtrl0, progVoltageCtrl1;
	logic [3:0] waitLen = 4'h0;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	int readyLow;
	always #5 clk_sys = ~clk_sys;
	always_comb
	begin
		isaPins = isa;
		isaPins.cdat = mdat;
		cardIn = cin;
		cardIn[0].waitN = mwaitN;
	end
	pcbr_bridge dut (.clk_sys(clk_sys), .rst_n(rst_n), .isaPins(isaPins), .cardIn(cardIn),
		.sdOut(sdOut), .sdOe(sdOe), .channelReadyOut(channelReadyOut),
		.zeroWaitOut_n(zeroWaitOut_n), .cardCtl(cardCtl), .cardAddr(cardAddr),
		.cardDataOut(cardDataOut), .cardDataOe(cardDataOe), .irqOut(irqOut),
		.cardSupplyEnable0(cardSupplyEnable0), .cardSupplyEnable1(cardSupplyEnable1),
		.progVoltageCtrl0(progVoltageCtrl0), .progVoltageCtrl1(progVoltageCtrl1));
	pcbr_card_model card (.clk_sys(clk_sys), .rst_n(rst_n), .ctl(cardCtl[0]),
		.addr(cardAddr), .waitLen(waitLen), .cdat(mdat), .waitN(mwaitN));
	// ****
	// Shared tasks
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize();
		if (miscompares == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			summarize();
		end
	end
	// Kind 0 I/O write, 1 I/O read, 2 memory write, 3 memory read
	task automatic cyc(input int kind, input logic [23:0] a, input logic [7:0] d, input logic bhN);
		@(negedge clk_sys);
		isa.addr = a;
		isa.sd = {8'h00, d};
		isa.sbheN = bhN;
		isa.iowN = (kind != 0);
		isa.iorN = (kind != 1);
		isa.memwN = (kind != 2);
		isa.memrN = (kind != 3);
		repeat (4) @(negedge clk_sys);
		ctlSeen = cardCtl[0];
		addrSeen = cardAddr;
		zwSeen = zeroWaitOut_n;
		readyLow = 0;
		while (channelReadyOut !== 1'b1 && readyLow < 40)
		begin
			readyLow++;
			@(negedge clk_sys);
		end
		check(readyLow < 40, 1'b1);
		// Minimum command width, so zero-wait cycles still return data
		repeat (4) @(negedge clk_sys);
		dataSeen = sdOut;
		oeSeen = kind[0] ? sdOe : cardDataOe;
		isa.iowN = 1'b1;
		isa.iorN = 1'b1;
		isa.memwN = 1'b1;
		isa.memrN = 1'b1;
		repeat (6) @(negedge clk_sys);
	endtask : cyc
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		cyc(0, {8'h00, pcbr_pkg::IO_INDEX}, idx, 1'b1);
		cyc(0, {8'h00, pcbr_pkg::IO_DATA}, v, 1'b1);
	endtask : wr
	task automatic rd(input logic [7:0] idx);
		cyc(0, {8'h00, pcbr_pkg::IO_INDEX}, idx, 1'b1);
		cyc(1, {8'h00, pcbr_pkg::IO_DATA}, 8'h00, 1'b1);
	endtask : rd
	// ****
	// Main sequence
	// ****
	initial
	begin
		logic [11:0] st, sp, lo;
		logic [13:0] off;
		logic [25:0] e;
		logic [15:0] ios, stp, x;
		logic [7:0] v;
		logic [3:0] L, M;
		int n0;
		isa = '1;
		isa.casSel = 1'b0;
		isa.aen = 1'b0;
		cin = '1;
		void'($urandom(32'hbe02));
		repeat (4) @(negedge clk_sys);
		check(channelReadyOut, 1'b1);
		check(cardCtl, {pcbr_pkg::CARD_IDLE, pcbr_pkg::CARD_IDLE});
		check(irqOut, 16'h0000);
		repeat (4) @(negedge clk_sys);
		rst_n = 1'b1;
		for (int s = 0; s < 2; s++)
		begin
			v = 8'($urandom);
			wr({1'b0, s[0], pcbr_pkg::R_VCTL}, {6'h00, v[1:0]});
			wr({1'b0, s[0], pcbr_pkg::R_PWR}, {6'h00, v[3:2]});
			check(cardSupplyEnable0[s], v[0]);
			check(cardSupplyEnable1[s], v[1]);
			check(progVoltageCtrl0[s], v[2]);
			check(progVoltageCtrl1[s], v[3]);
			rd({1'b0, s[0], pcbr_pkg::R_PWR});
			check(dataSeen[1:0], v[3:2]);
			check(oeSeen, 1'b1);
		end
		wr({2'b00, pcbr_pkg::R_PWR}, 8'h00);
		isa.casSel = 1'b1;
		wr({2'b00, pcbr_pkg::R_PWR}, 8'h03);
		check(progVoltageCtrl0[0], 1'b0);
		wr({2'b10, pcbr_pkg::R_PWR}, 8'h03);
		check(progVoltageCtrl0[0], 1'b1);
		wr({2'b11, pcbr_pkg::R_PWR}, 8'h02);
		check({progVoltageCtrl1[1], progVoltageCtrl0[1]}, 2'b10);
		isa.casSel = 1'b0;
		st = 12'h100 + 12'($urandom_range(0, 12'h7ff));
		sp = st + 12'h001;
		lo = 12'($urandom) & 12'hffe;
		off = 14'($urandom);
		e = {2'b00, st, lo} + {off, 12'h000};
		x = e[15:0] ^ 16'ha5c3;
		wr(8'h10, st[7:0]);
		wr(8'h11, {4'h0, st[11:8]});
		wr(8'h12, sp[7:0]);
		wr(8'h13, {4'h0, sp[11:8]});
		wr(8'h14, off[7:0]);
		wr(8'h15, {2'b00, off[13:8]});
		cyc(3, {st, lo}, 8'h00, 1'b1);
		check(ctlSeen, pcbr_pkg::CARD_IDLE);
		wr({2'b00, pcbr_pkg::R_WINEN}, 8'h01);
		cyc(3, {st, lo}, 8'h00, 1'b1);
		check(addrSeen, e);
		check(ctlSeen.oeN, 1'b0);
		check({ctlSeen.ce1N, ctlSeen.ce2N}, 2'b01);
		check(dataSeen[7:0], x[7:0]);
		cyc(3, {st - 12'h001, lo}, 8'h00, 1'b1);
		check(ctlSeen, pcbr_pkg::CARD_IDLE);
		cyc(3, {st + 12'h002, lo}, 8'h00, 1'b1);
		check(ctlSeen, pcbr_pkg::CARD_IDLE);
		wr({2'b00, pcbr_pkg::R_IGC}, 8'h10);
		wr(8'h11, {4'hc, st[11:8]});
		wr(8'h15, {2'b01, off[13:8]});
		cyc(3, {st, lo}, 8'h00, 1'b0);
		check({ctlSeen.ce1N, ctlSeen.ce2N}, 2'b00);
		check(ctlSeen.regN, 1'b0);
		check(zwSeen, 1'b0);
		wr({2'b00, pcbr_pkg::R_IGC}, 8'h00);
		wr(8'h11, {4'h0, st[11:8]});
		cyc(3, {st, lo}, 8'h00, 1'b1);
		n0 = readyLow;
		wr(8'h11, {4'h2, st[11:8]});
		cyc(3, {st, lo}, 8'h00, 1'b1);
		check(readyLow, n0 + 2);
		wr(8'h11, {4'h0, st[11:8]});
		waitLen = 4'h5;
		cyc(3, {st, lo}, 8'h00, 1'b1);
		check(readyLow > n0 + 2, 1'b1);
		waitLen = 4'h0;
		cyc(2, {st, lo}, v, 1'b1);
		check(ctlSeen.weN, 1'b0);
		check(oeSeen, 1'b1);
		check(cardDataOut, {8'h00, v});
		ios = 16'h4000 + 16'($urandom_range(0, 12'hfff));
		stp = ios + 16'($urandom_range(1, 255));
		x = stp ^ 16'ha5c3;
		wr(8'h08, ios[7:0]);
		wr(8'h09, ios[15:8]);
		wr(8'h0a, stp[7:0]);
		wr(8'h0b, stp[15:8]);
		wr({2'b00, pcbr_pkg::R_IOCTL}, 8'h04);
		wr({2'b00, pcbr_pkg::R_WINEN}, 8'h41);
		cyc(1, {8'h00, stp}, 8'h00, 1'b1);
		check({ctlSeen.iordN, ctlSeen.regN, ctlSeen.oeN, ctlSeen.weN}, 4'b0011);
		check(addrSeen[15:0], stp);
		check({ctlSeen.ce1N, ctlSeen.ce2N}, 2'b01);
		check(zwSeen, 1'b0);
		check(dataSeen[7:0], x[7:0]);
		cyc(1, {8'h00, stp + 16'h0001}, 8'h00, 1'b1);
		check(ctlSeen, pcbr_pkg::CARD_IDLE);
		cin[0].cdA = 1'b0;
		cin[0].cdB = 1'b0;
		rd({2'b00, pcbr_pkg::R_IFSTAT});
		check(dataSeen[3:2], 2'b11);
		check(dataSeen[5], 1'b1);
		L = 4'($urandom_range(1, 15));
		M = 4'($urandom_range(1, 15));
		wr({2'b00, pcbr_pkg::R_CSCCFG}, {L, 4'h8});
		check(irqOut[L], 1'b1);
		wr({2'b00, pcbr_pkg::R_CSC}, 8'h08);
		check(irqOut, 16'h0000);
		wr({2'b00, pcbr_pkg::R_IGC}, {4'h2, M});
		cin[0].rdy = 1'b0;
		repeat (6) @(negedge clk_sys);
		check(irqOut[M], 1'b1);
		cin[0].rdy = 1'b1;
		repeat (6) @(negedge clk_sys);
		check(irqOut[M], 1'b0);
		wr({2'b00, pcbr_pkg::R_GCTL}, 8'h02);
		check(irqOut[M], 1'b1);
		summarize();
	end
endmodule : tb_isa_to_pc_card_bridge
